// File: hdl/wcb_byte_lanes.sv
/*
  expands a store (offset, size, data) into a 64-byte lane mask and a
  lane-aligned data word.
  assumes stores are naturally aligned inside the line.
*/
`timescale 1ns/1ps
`include "wcb_cfg.svh"

module wcb_byte_lanes
  import wcb_pkg::*;
(
  input wire logic [`WCB_OFS_BITS-1:0] ofs,
  input wire logic [1:0] size,
  input wire logic [63:0] data,
  output wcb_mask_t mask,
  output wcb_data_t lane_data
);
  // ---------------------------------------------------------------
  // lane expansion
  // ---------------------------------------------------------------
  wire logic [7:0] len_mask;
  assign len_mask = 8'((9'h2 << ((9'h1 << size) - 9'h1)) - 9'h1);
  // one generate loop builds each byte lane
  genvar g;
  generate
    for (g = 0; g < `WCB_LINE_BYTES; g++) begin : g_lane
      wire logic [6:0] rel;
      assign rel = 7'(g) - {1'b0, ofs};
      assign mask[g] = (rel < 7'h8) && len_mask[rel[2:0]];
      assign lane_data[g*8 +: 8] = data[rel[2:0]*8 +: 8];
    end
  endgenerate
endmodule // wcb_byte_lanes

// File: hdl/wcb_pend_ctr.sv
/*
  counts system writes that were sent and not yet acknowledged.
  assumes at most one issue and one acknowledge per cycle.
*/
`timescale 1ns/1ps
`include "wcb_cfg.svh"

module wcb_pend_ctr
  import wcb_pkg::*;
#(
  parameter int MAX_PEND = `WCB_MAX_PEND
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic issue,
  input wire logic ack,
  output logic room
);
  // ---------------------------------------------------------------
  // outstanding count
  // ---------------------------------------------------------------
  logic [`WCB_PEND_BITS-1:0] cnt_q;
  wire logic [`WCB_PEND_BITS-1:0] cnt_d;
  assign cnt_d = cnt_q + {3'h0, issue} - {3'h0, ack && cnt_q != '0};
  assign room = cnt_q < `WCB_PEND_BITS'(MAX_PEND);
  // counter register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end
endmodule // wcb_pend_ctr

// File: hdl/wcb_top.sv
/*
  store-merging buffers: four 64-byte line buffers that merge combining-type
  and streaming stores, close on completion events and send lines in the
  order they were opened to the northbridge request path.
  assumes the store pipeline holds a store while st_ready is low and the
  request path holds a write while wr_ready is low.
*/
// Overview of operation
// - merge byte/word/dword/qword stores within one aligned 64-byte line buffer.
// - combining-type stores merge in any order until the buffer is full.
// - other types do not merge, except streaming-overridden write-back stores.
// - streaming buffers close on the same events as combining buffers.
// - a close sends the affected buffer and all older ones, full or not.
// - port input or output closes merging in open buffers.
// - serializing operations close merging.
// - flush operations send all open buffers to the system.
// - merging closes before a lock starts; stores inside the lock may merge.
// - an uncached load always closes merging.
// - a combining load closes merging only on a line address match.
// - store hitting a buffer of another memory type closes and flushes it.
// - a buffer closes once all 64 bytes are valid.
// - a table-walk setting accessed or dirty bits closes merging.
// - a fully valid buffer goes out as one 64-byte write.
// - four buffers, each tracking one line stream.
// - up to eight system writes may be outstanding.
// - streaming stores share the buffer pool with combining stores.
// - flushed buffers go out in the order their streams opened.
`timescale 1ns/1ps
`include "wcb_cfg.svh"

module wcb_top
  import wcb_pkg::*;
#(
  parameter int NUM_BUF = `WCB_NUM_BUF,
  parameter int MAX_PEND = `WCB_MAX_PEND
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic st_valid,
  output logic st_ready,
  input wire logic [`WCB_ADDR_BITS-1:0] st_addr,
  input wire logic [1:0] st_size,
  input wire logic [63:0] st_data,
  input wire logic [2:0] st_mtype,
  input wire logic st_nontemporal,
  input wire logic ld_valid,
  input wire logic [`WCB_ADDR_BITS-1:0] ld_addr,
  input wire logic [2:0] ld_mtype,
  input wire logic [`WCB_EV_BITS-1:0] close_ev,
  output logic close_busy,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [`WCB_ADDR_BITS-1:0] wr_addr,
  output logic [`WCB_LINE_BYTES-1:0] wr_mask,
  output logic [`WCB_LINE_BYTES*8-1:0] wr_data,
  output logic wr_full_line,
  input wire logic wr_ack
);
  localparam int IW = $clog2(NUM_BUF);

  // ---------------------------------------------------------------
  // buffer storage
  // ---------------------------------------------------------------
  logic [NUM_BUF-1:0] vld_q;
  logic [NUM_BUF-1:0] cls_q;
  wcb_line_t line_q [NUM_BUF];
  wcb_mask_t mask_q [NUM_BUF];
  wcb_data_t data_q [NUM_BUF];
  wcb_mtype_t type_q [NUM_BUF];
  logic [IW-1:0] age_q [NUM_BUF];
  wcb_state_t state_q;
  logic [IW-1:0] sel_q;
  logic [`WCB_ADDR_BITS-1:0] wr_addr_q;
  wcb_mask_t wr_mask_q;
  wcb_data_t wr_data_q;

  // ---------------------------------------------------------------
  // store classification
  // ---------------------------------------------------------------
  wire wcb_line_t st_line;
  wire wcb_line_t ld_line;
  wire wcb_mtype_t st_eff;
  wire logic st_comb;
  wire wcb_mask_t st_mask;
  wire wcb_data_t st_lanes;
  assign st_line = st_addr[`WCB_ADDR_BITS-1:`WCB_OFS_BITS];
  assign ld_line = ld_addr[`WCB_ADDR_BITS-1:`WCB_OFS_BITS];
  // streaming write-back stores behave as combining type
  assign st_eff = (st_nontemporal && st_mtype == `WCB_MT_WB) ? `WCB_MT_WC : st_mtype;
  assign st_comb = st_eff == `WCB_MT_WC;

  wcb_byte_lanes u_lanes (
    .ofs(st_addr[`WCB_OFS_BITS-1:0]),
    .size(st_size),
    .data(st_data),
    .mask(st_mask),
    .lane_data(st_lanes)
  );

  // ---------------------------------------------------------------
  // per-buffer hits and full flags
  // ---------------------------------------------------------------
  wire logic [NUM_BUF-1:0] st_hit;
  wire logic [NUM_BUF-1:0] ld_hit;
  wire logic [NUM_BUF-1:0] full;
  wire logic [NUM_BUF-1:0] type_diff;
  wire logic [NUM_BUF-1:0] open_buf;
  genvar g;
  generate
    for (g = 0; g < NUM_BUF; g++) begin : g_buf
      assign open_buf[g] = vld_q[g] && !cls_q[g];
      assign st_hit[g] = open_buf[g] && line_q[g] == st_line;
      assign ld_hit[g] = open_buf[g] && line_q[g] == ld_line;
      assign full[g] = &mask_q[g];
      assign type_diff[g] = st_hit[g] && type_q[g] != st_eff;
    end
  endgenerate

  // ---------------------------------------------------------------
  // close decisions
  // ---------------------------------------------------------------
  wire logic global_close;
  wire logic ld_close;
  wire logic any_hit;
  wire logic all_busy;
  wire logic type_close;
  wire logic evict;
  assign ld_close = ld_valid && ((ld_mtype == `WCB_MT_UC) ||
                    (ld_mtype == `WCB_MT_WC && |ld_hit));
  // io, serializing, flush, lock and table-walk events close all buffers
  assign global_close = |close_ev || ld_close;
  assign any_hit = |st_hit;
  assign all_busy = &vld_q;
  assign type_close = st_valid && |type_diff;
  assign evict = st_valid && st_comb && !any_hit && all_busy;
  // a store merges only when nothing is draining
  wire logic drain_busy;
  assign drain_busy = |cls_q || state_q != WCB_IDLE;
  assign close_busy = drain_busy || global_close;
  // merging resumes once the drain is done, so stores inside the lock merge
  assign st_ready = st_valid && !drain_busy && !global_close && !type_close && !evict &&
                    (st_comb ? 1'b1 : !any_hit);

  // free slot choice and age bookkeeping
  logic [IW-1:0] free_idx;
  logic [IW-1:0] full_age;
  always_comb begin
    free_idx = '0;
    full_age = '0;
    for (int i = NUM_BUF - 1; i >= 0; i--) begin
      if (!vld_q[i]) free_idx = IW'(i);
      // youngest full buffer sets how far a full-line close reaches
      if (vld_q[i] && full[i] && age_q[i] > full_age) full_age = age_q[i];
    end
  end
  wire logic alloc;
  wire logic merge;
  logic [IW-1:0] hit_idx;
  logic [IW-1:0] nvld;
  always_comb begin
    hit_idx = '0;
    nvld = '0;
    for (int i = 0; i < NUM_BUF; i++) begin
      if (st_hit[i]) hit_idx = IW'(i);
      if (vld_q[i]) nvld = nvld + 1'b1;
    end
  end
  assign merge = st_ready && st_comb && any_hit;
  assign alloc = st_ready && st_comb && !any_hit;
  // close target age: everything no younger is closed with it
  wire logic [IW-1:0] tgt_age;
  wire logic tgt_en;
  assign tgt_en = type_close || evict;
  assign tgt_age = evict ? '0 : age_q[hit_idx];

  // ---------------------------------------------------------------
  // drain sequencer
  // ---------------------------------------------------------------
  wire logic room;
  wire logic send_fire;
  logic [IW-1:0] drain_idx;
  logic drain_any;
  always_comb begin
    drain_idx = '0;
    drain_any = 1'b0;
    for (int i = 0; i < NUM_BUF; i++) begin
      if (cls_q[i] && age_q[i] == '0) begin
        drain_idx = IW'(i);
        drain_any = 1'b1;
      end
    end
  end
  assign send_fire = wr_valid && wr_ready;

  wcb_pend_ctr #(.MAX_PEND(MAX_PEND)) u_pend (
    .clk(clk),
    .resetn(resetn),
    .issue(send_fire),
    .ack(wr_ack),
    .room(room)
  );

  wcb_state_t state_d;
  always_comb begin
    state_d = state_q;
    case (state_q)
      WCB_IDLE: if (drain_any && room) state_d = WCB_DRAIN;
      WCB_DRAIN: state_d = WCB_SEND;
      WCB_SEND: if (send_fire) state_d = WCB_IDLE;
      default: state_d = WCB_IDLE;
    endcase
  end

  // state and output capture: oldest closed buffer goes out first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= WCB_IDLE;
      sel_q <= '0;
      wr_addr_q <= '0;
      wr_mask_q <= '0;
      wr_data_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == WCB_IDLE && drain_any && room) begin
        sel_q <= drain_idx;
        wr_addr_q <= {line_q[drain_idx], `WCB_OFS_BITS'(0)};
        wr_mask_q <= mask_q[drain_idx];
        wr_data_q <= data_q[drain_idx];
      end
    end
  end
  assign wr_valid = state_q == WCB_SEND;
  assign wr_addr = wr_addr_q;
  assign wr_mask = wr_mask_q;
  assign wr_data = wr_data_q;
  assign wr_full_line = &wr_mask_q;

  // ---------------------------------------------------------------
  // buffer update
  // ---------------------------------------------------------------
  wire logic retire;
  assign retire = state_q == WCB_DRAIN;
  generate
    for (g = 0; g < NUM_BUF; g++) begin : g_upd
      wire logic wr_here;
      wire logic new_here;
      wire logic close_here;
      wire logic free_here;
      assign new_here = alloc && free_idx == IW'(g);
      assign wr_here = (merge && hit_idx == IW'(g)) || new_here;
      assign free_here = retire && sel_q == IW'(g);
      assign close_here = vld_q[g] && (global_close ||
                          (|(vld_q & full) && age_q[g] <= full_age) ||
                          (tgt_en && age_q[g] <= tgt_age));
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          vld_q[g] <= 1'b0;
          cls_q[g] <= 1'b0;
          line_q[g] <= '0;
          mask_q[g] <= '0;
          data_q[g] <= '0;
          type_q[g] <= '0;
          age_q[g] <= '0;
        end else if (free_here) begin
          vld_q[g] <= 1'b0;
          cls_q[g] <= 1'b0;
          mask_q[g] <= '0;
          line_q[g] <= '0;
          type_q[g] <= '0;
          data_q[g] <= '0;
          age_q[g] <= '0;
        end else begin
          if (retire && vld_q[g] && age_q[g] != '0) age_q[g] <= age_q[g] - 1'b1;
          if (close_here) cls_q[g] <= 1'b1;
          if (new_here) begin
            vld_q[g] <= 1'b1;
            line_q[g] <= st_line;
            type_q[g] <= st_eff;
            age_q[g] <= nvld;
            mask_q[g] <= st_mask;
            data_q[g] <= st_lanes;
          end else if (wr_here) begin
            mask_q[g] <= mask_q[g] | st_mask;
            for (int b = 0; b < `WCB_LINE_BYTES; b++) begin
              if (st_mask[b]) data_q[g][b*8 +: 8] <= st_lanes[b*8 +: 8];
            end
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_full_closes;
    @(posedge clk) disable iff (!resetn)
      (vld_q[0] && &mask_q[0] && !cls_q[0]) |=> cls_q[0] || !vld_q[0];
  endproperty
  a_full_closes: assert property (p_full_closes) else $error("full buffer left open");

  property p_event_closes;
    @(posedge clk) disable iff (!resetn)
      (|close_ev && |vld_q) |=> (vld_q & ~cls_q) == '0;
  endproperty
  a_event_closes: assert property (p_event_closes) else $error("event left buffer open");

  property p_ucld_closes;
    @(posedge clk) disable iff (!resetn)
      (ld_valid && ld_mtype == `WCB_MT_UC) |-> !st_ready;
  endproperty
  a_ucld_closes: assert property (p_ucld_closes) else $error("merge during uc load");

  property p_wcld_nomatch;
    @(posedge clk) disable iff (!resetn)
      (ld_valid && ld_mtype == `WCB_MT_WC && ld_hit == '0 && close_ev == '0 && !drain_busy)
      |-> !global_close;
  endproperty
  a_wcld_nomatch: assert property (p_wcld_nomatch) else $error("wc load miss closed");

  property p_noncomb_nomerge;
    @(posedge clk) disable iff (!resetn)
      (st_valid && !st_comb) |-> !merge && !alloc;
  endproperty
  a_noncomb_nomerge: assert property (p_noncomb_nomerge) else $error("non wc merged");

  property p_type_diff;
    @(posedge clk) disable iff (!resetn)
      (st_valid && |type_diff) |=> |cls_q;
  endproperty
  a_type_diff: assert property (p_type_diff) else $error("type mismatch not closed");

  property p_send_oldest;
    @(posedge clk) disable iff (!resetn)
      (state_q == WCB_DRAIN) |-> age_q[sel_q] == '0 && cls_q[sel_q];
  endproperty
  a_send_oldest: assert property (p_send_oldest) else $error("sent out of age order");

  property p_full_flag;
    @(posedge clk) disable iff (!resetn)
      (state_q == WCB_DRAIN) |-> wr_full_line == full[sel_q];
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full line flag wrong");

  property p_hold;
    @(posedge clk) disable iff (!resetn)
      (wr_valid && !wr_ready) |=> wr_valid && $stable(wr_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("write dropped under stall");

  property p_pend_limit;
    @(posedge clk) disable iff (!resetn)
      (state_q == WCB_IDLE && !room) |=> state_q == WCB_IDLE;
  endproperty
  a_pend_limit: assert property (p_pend_limit) else $error("ninth write started");

  property p_free_clears;
    @(posedge clk) disable iff (!resetn)
      retire |=> !vld_q[$past(sel_q)] || $past(alloc);
  endproperty
  a_free_clears: assert property (p_free_clears) else $error("buffer not freed");
endmodule // wcb_top

// File: inc/wcb_cfg.svh
/*
  constants for the store-merging buffers: line size, pool size, outstanding
  write limit, memory type codes and close-event vector positions.
  assumes inclusion by bare name from the package and the design files.
*/
`ifndef WCB_CFG_SVH
`define WCB_CFG_SVH

// ---------------------------------------------------------------
// geometry
// ---------------------------------------------------------------
`define WCB_LINE_BYTES 64
`define WCB_OFS_BITS 6
`define WCB_ADDR_BITS 40
`define WCB_NUM_BUF 4
`define WCB_MAX_PEND 8
`define WCB_PEND_BITS 4

// ---------------------------------------------------------------
// memory type codes
// ---------------------------------------------------------------
`define WCB_MT_UC 3'h0
`define WCB_MT_WC 3'h1
`define WCB_MT_WT 3'h4
`define WCB_MT_WP 3'h5
`define WCB_MT_WB 3'h6

// ---------------------------------------------------------------
// store sizes (log2 bytes)
// ---------------------------------------------------------------
`define WCB_SZ_B 2'h0
`define WCB_SZ_W 2'h1
`define WCB_SZ_D 2'h2
`define WCB_SZ_Q 2'h3

// ---------------------------------------------------------------
// close event bits
// ---------------------------------------------------------------
`define WCB_EV_IO 0
`define WCB_EV_SER 1
`define WCB_EV_FLUSH 2
`define WCB_EV_LOCK 3
`define WCB_EV_TLBAD 4
`define WCB_EV_BITS 5

`endif

// File: inc/wcb_pkg.sv
/*
  types shared by the store-merging buffer modules.
  assumes wcb_cfg.svh is on the include path.
*/
`include "wcb_cfg.svh"

package wcb_pkg;
  typedef logic [2:0] wcb_mtype_t;
  typedef logic [`WCB_ADDR_BITS-1:`WCB_OFS_BITS] wcb_line_t;
  typedef logic [`WCB_LINE_BYTES-1:0] wcb_mask_t;
  typedef logic [`WCB_LINE_BYTES*8-1:0] wcb_data_t;
  typedef enum logic [1:0] {
    WCB_IDLE = 2'b00,
    WCB_DRAIN = 2'b01,
    WCB_SEND = 2'b10
  } wcb_state_t;
endpackage

// File: tb/wcb_sys_model.sv
/*
  behavioural model of the northbridge request path for the merging buffers:
  accepts system writes with a prompt or slow ready and acknowledges each one.
  assumes one clock and active-low reset shared with the design.
*/
`timescale 1ns/1ps
`include "wcb_cfg.svh"

module wcb_sys_model
  import wcb_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic hold_ack,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic wr_ack
);
  int wait_q;
  int pend_q;
  int pend_d;
  logic take;

  // ---------------------------------------------------------------
  // accept and acknowledge
  // ---------------------------------------------------------------
  // ready rises no earlier than one cycle after valid, later when slow
  assign take = wr_valid && wr_ready;
  // held acks pile up so the design's outstanding limit can be reached
  assign pend_d = pend_q + int'(take) - int'(wr_ack);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 0;
      pend_q <= 0;
      wr_ready <= 1'b0;
      wr_ack <= 1'b0;
    end else begin
      wait_q <= (wr_valid && !wr_ready) ? wait_q + 1 : 0;
      wr_ready <= wr_valid && !wr_ready && (wait_q >= (slow ? 2 : 0));
      pend_q <= pend_d;
      wr_ack <= !hold_ack && (pend_d != 0);
    end
  end
endmodule // wcb_sys_model

// File: tb/wcb_top_test.sv
/*
  self-checking bench for the store-merging buffers: stores, loads and close
  events go in, system writes are captured and compared in order.
  assumes wcb_sys_model stands at the request path side.
*/
`timescale 1ns/1ps
`include "wcb_cfg.svh"

module wcb_top_test
  import wcb_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, st_valid = 1'b0, st_ready, st_nontemporal = 1'b0;
  logic [`WCB_ADDR_BITS-1:0] st_addr = '0, ld_addr = '0, wr_addr;
  logic [1:0] st_size = 2'h0;
  logic [63:0] st_data = 64'h0;
  logic [2:0] st_mtype = 3'h0, ld_mtype = 3'h0;
  logic ld_valid = 1'b0, close_busy, wr_valid, wr_ready, wr_full_line, wr_ack;
  logic [`WCB_EV_BITS-1:0] close_ev = '0;
  wcb_mask_t wr_mask;
  wcb_data_t wr_data;
  logic slow = 1'b0, hold_ack = 1'b0;
  int bad_count = 0, checks_done = 0, cycles = 0;
  logic [`WCB_ADDR_BITS-1:0] q_addr[$];
  wcb_mask_t q_mask[$];
  wcb_data_t q_data[$];
  logic q_full[$];

  always #4 clk = ~clk;

  wcb_top wcb_top_i (.clk(clk), .resetn(resetn), .st_valid(st_valid), .st_ready(st_ready),
    .st_addr(st_addr), .st_size(st_size), .st_data(st_data), .st_mtype(st_mtype),
    .st_nontemporal(st_nontemporal), .ld_valid(ld_valid), .ld_addr(ld_addr),
    .ld_mtype(ld_mtype), .close_ev(close_ev), .close_busy(close_busy), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_mask(wr_mask), .wr_data(wr_data),
    .wr_full_line(wr_full_line), .wr_ack(wr_ack));

  wcb_sys_model wcb_sys_model_i (.clk(clk), .resetn(resetn), .slow(slow),
    .hold_ack(hold_ack), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_ack(wr_ack));

  // ---------------------------------------------------------------
  // write capture and hang guard
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      q_addr.push_back(wr_addr);
      q_mask.push_back(wr_mask);
      q_data.push_back(wr_data);
      q_full.push_back(wr_full_line);
    end
    if (cycles > 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  // store held until st_ready is seen before a rising edge
  task automatic do_store(input logic [39:0] a, input logic [1:0] sz, input logic [63:0] d,
                          input logic [2:0] mt, input logic nt);
    int n;
    @(negedge clk);
    st_valid = 1'b1; st_addr = a; st_size = sz; st_data = d; st_mtype = mt;
    st_nontemporal = nt;
    for (n = 0; n < 300; n++) begin
      #1;
      if (st_ready === 1'b1) break;
      @(negedge clk);
    end
    check(n < 300, "store never taken");
    @(negedge clk);
    st_valid = 1'b0;
  endtask

  task automatic pulse_ev(input int bit_n);
    @(negedge clk);
    close_ev = '0;
    close_ev[bit_n] = 1'b1;
    @(negedge clk);
    close_ev = '0;
  endtask

  task automatic pulse_ld(input logic [39:0] a, input logic [2:0] mt);
    @(negedge clk);
    ld_valid = 1'b1; ld_addr = a; ld_mtype = mt;
    @(negedge clk);
    ld_valid = 1'b0;
  endtask

  // next captured write must carry this line, mask and full flag
  task automatic expect_wr(input logic [39:0] a, input wcb_mask_t m, input logic f);
    int n;
    for (n = 0; n < 200 && q_addr.size() == 0; n++) @(negedge clk);
    check(q_addr.size() != 0, "expected write missing");
    if (q_addr.size() != 0) begin
      check(q_addr[0] === {a[39:6], 6'h00}, "write line address wrong");
      check(q_mask[0] === m, "write byte mask wrong");
      check(q_full[0] === f, "full line flag wrong");
      void'(q_addr.pop_front());
      void'(q_mask.pop_front());
      void'(q_full.pop_front());
    end
  endtask

  task automatic no_wr(input int n);
    repeat (n) @(negedge clk);
    check(q_addr.size() == 0, "unexpected write");
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_merge();
    q_data.delete();
    do_store(40'h10_0000_0003, `WCB_SZ_B, 64'h5a, `WCB_MT_WC, 1'b0);
    do_store(40'h10_0000_0008, `WCB_SZ_Q, 64'h0123_4567_89ab_cdef, `WCB_MT_WC, 1'b0);
    do_store(40'h10_0000_003e, `WCB_SZ_W, 64'hbeef, `WCB_MT_WC, 1'b0);
    no_wr(10);
    pulse_ev(`WCB_EV_FLUSH);
    expect_wr(40'h10_0000_0000, 64'hc000_0000_0000_ff08, 1'b0);
    check(q_data[0][31:24] === 8'h5a && q_data[0][127:64] === 64'h0123_4567_89ab_cdef
          && q_data[0][511:496] === 16'hbeef, "merged data wrong");
  endtask

  task automatic t_full();
    for (int i = 7; i >= 0; i--)
      do_store(40'h20_0000_0000 + 40'(i * 8), `WCB_SZ_Q, 64'(i), `WCB_MT_WC, 1'b0);
    expect_wr(40'h20_0000_0000, {64{1'b1}}, 1'b1);
  endtask

  task automatic t_events();
    for (int e = 0; e < `WCB_EV_BITS; e++) begin
      slow = e[0];
      do_store(40'h30_0000_00c0, `WCB_SZ_D, 64'h11, (e == 2) ? `WCB_MT_WB : `WCB_MT_WC,
               e == 2);
      do_store(40'h30_0000_0080, `WCB_SZ_D, 64'h22, `WCB_MT_WC, e == 2);
      pulse_ev(e);
      check(close_busy === 1'b1, "close not reported busy");
      expect_wr(40'h30_0000_00c0, 64'h0000_0000_0000_000f, 1'b0);
      expect_wr(40'h30_0000_0080, 64'h0000_0000_0000_000f, 1'b0);
      check(close_busy === 1'b0, "busy after drain");
    end
    slow = 1'b0;
  endtask

  task automatic t_loads();
    // an uncached store passes without opening a buffer
    do_store(40'h40_0000_0000, `WCB_SZ_B, 64'h9, `WCB_MT_UC, 1'b0);
    no_wr(10);
    // an uncached store hitting an open line closes it first
    do_store(40'h40_0000_0000, `WCB_SZ_B, 64'h9, `WCB_MT_WC, 1'b0);
    do_store(40'h40_0000_0001, `WCB_SZ_B, 64'h9, `WCB_MT_UC, 1'b0);
    expect_wr(40'h40_0000_0000, 64'h1, 1'b0);
    no_wr(10);
    do_store(40'h40_0000_0100, `WCB_SZ_B, 64'h1, `WCB_MT_WC, 1'b0);
    pulse_ld(40'h40_0000_0500, `WCB_MT_WC);
    no_wr(20);
    pulse_ld(40'h40_0000_0120, `WCB_MT_WC);
    expect_wr(40'h40_0000_0100, 64'h1, 1'b0);
    do_store(40'h40_0000_0101, `WCB_SZ_B, 64'h1, `WCB_MT_WC, 1'b0);
    pulse_ld(40'h50_0000_0000, `WCB_MT_UC);
    expect_wr(40'h40_0000_0100, 64'h2, 1'b0);
  endtask

  task automatic t_evict();
    for (int i = 0; i < 5; i++)
      do_store(40'h60_0000_0000 + 40'(i * 64), `WCB_SZ_B, 64'h7, `WCB_MT_WC, 1'b0);
    expect_wr(40'h60_0000_0000, 64'h1, 1'b0);
    no_wr(10);
    pulse_ev(`WCB_EV_SER);
    for (int i = 1; i < 5; i++)
      expect_wr(40'h60_0000_0000 + 40'(i * 64), 64'h1, 1'b0);
  endtask

  task automatic t_pend();
    hold_ack = 1'b1;
    for (int i = 0; i < 9; i++) begin
      do_store(40'h70_0000_0000 + 40'(i * 64), `WCB_SZ_B, 64'h3, `WCB_MT_WC, 1'b0);
      pulse_ev(`WCB_EV_FLUSH);
      if (i < 8) expect_wr(40'h70_0000_0000 + 40'(i * 64), 64'h1, 1'b0);
    end
    no_wr(40);
    hold_ack = 1'b0;
    expect_wr(40'h70_0000_0200, 64'h1, 1'b0);
    no_wr(20);
  endtask

  task automatic print_verdict();
    $display("checks %0d, errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    check(wr_valid === 1'b0, "write after reset");
    t_merge();
    t_full();
    t_events();
    t_loads();
    t_evict();
    t_pend();
    print_verdict();
  end
endmodule // wcb_top_test
